// File: pkg/est_defines.vh
/*
 Constants of the elapsed seconds timer: register offsets, field positions,
 reset values and delays. Included by the timer's design file and by its
 bench, which takes its expected values from here.
*/
`ifndef EST_DEFINES_VH
`define EST_DEFINES_VH

// Register byte offsets
`define EST_OFF_MODE      8'h00
`define EST_OFF_ALARM     8'h04
`define EST_OFF_COUNT     8'h08
`define EST_OFF_STATUS    8'h0c
`define EST_OFF_EVT_CLR   8'h10

// Mode register fields
`define EST_DIV_MSB       15
`define EST_ALM_IEN_BIT   16
`define EST_TICK_IEN_BIT  17
`define EST_RESTART_BIT   18

// Status register fields
`define EST_ALM_FLAG_BIT  0
`define EST_TICK_FLAG_BIT 1

// Reset values
`define EST_MODE_RST      32'h0000_8000
`define EST_ALARM_RST     32'hffff_ffff
`define EST_COUNT_RST     32'h0000_0000

// Slow clock edges between a request and its effect
`define EST_SYNC_SLOW     2'h2

`endif

// File: rtl/est_timer.v
/*
 Elapsed seconds timer: 32-bit count fed by the slow clock through a
 16-bit prescaler, tick and alarm flags, one interrupt, APB slave.
 Assumes slow_clk is a free running slow clock slower than sys_clk/4,
 and an APB master on sys_clk.

 Register map, byte addresses on paddr:
   0x00 timer_mode_control: [15:0] prescale_divisor, [16] alarm_irq_enable,
        [17] tick_irq_enable, [18] restart_divider (write pulse, reads 0)
   0x04 alarm_compare: alarm_compare_value, all ones after reset
   0x08 current_count: current_count_value, read only
   0x0c event_status: [0] alarm_flag, [1] tick_flag, read clears both
   0x10 event clear: write ones to clear single flags, reads 0
   Other addresses answer with pslverr and have no side effect.

 Bus timing: one wait state on every transfer; pready, prdata and
 pslverr are registered and stand for one cycle.

 Slow domain: slow_clk passes two flip-flops and a third for the edge;
 each detected rising edge is one slow tick, two or three sys_clk cycles
 after the pin edge. Restart and flag clearing land on the second slow
 tick after the bus edge that asks for them; a new request restarts it.

 Limitations a user must know:
   Divisors of 1 or 2 may lose tick events, since clearing lags.
   The interrupt may stand two slow cycles after a status read, so a
   handler masks it and unmasks once the flags read as clear.
   The count moves with the slow clock; read it twice until equal.
   A divisor change without restart applies at the next compare; if the
   prescaler has already passed the new end it runs through 65536 ticks.
   Writes to the count and status registers are ignored.
   Alarm compare is direct equality and sets the flag while equal.
*/
`timescale 1ns/100ps
`include "est_defines.vh"

// Function
// - Count advances once per prescaler period of slow clock, divisor is 16 bits.
// - Divisor zero means a period of 65536 slow clocks, else the divisor.
// - Count wraps from all ones to zero silently.
// - Every count increment sets the tick flag, held until status read or event clear write.
// - Count equal to alarm register sets the alarm flag.
// - Alarm register resets to all ones.
// - Reading status clears tick and alarm flags.
// - Flag clearing lands two slow clock edges after the read.
// - Writing restart reloads prescaler and zeroes the count.
// - Restart becomes effective two slow clock edges after the write.
// - Alarm interrupt enable lets alarm flag drive the interrupt.
// - Tick interrupt enable lets tick flag drive the interrupt.
// - Prescale divisor resets to 0x8000.
module est_timer (
  // Clock and reset
  input  wire        sys_clk,
  input  wire        rst,
  // Slow clock, asynchronous
  input  wire        slow_clk,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // Interrupt
  output reg         irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  reg  [2:0]  slow_sync_ff;
  reg  [15:0] mode_div_ff;
  reg  [1:0]  mode_ien_ff;
  reg  [31:0] alarm_ff;
  reg  [31:0] count_ff;
  reg  [15:0] presc_ff;
  reg  [1:0]  flags_ff;
  reg  [1:0]  clr_mask_ff;
  reg  [1:0]  clr_wait_ff;
  reg         rst_pend_ff;
  reg  [1:0]  rst_wait_ff;
  reg  [1:0]  nxt_flags;
  reg  [31:0] nxt_rdata;
  reg         nxt_err;
  wire        slow_tick;
  wire        acc_done;
  wire        wr_done;
  wire        rd_done;
  wire        inc_now;
  wire        alm_now;
  wire        restart_wr;
  wire        status_rd;
  wire        evt_clr_wr;
  wire        clr_fire;
  wire        rst_fire;
  wire        mode_wr;
  wire        alarm_wr;
  reg  [2:0]  nxt_slow_sync;
  reg         nxt_ready;
  reg         nxt_slverr;
  reg  [31:0] nxt_prdata;
  reg  [15:0] nxt_mode_div;
  reg  [1:0]  nxt_mode_ien;
  reg  [31:0] nxt_alarm;
  reg         nxt_rst_pend;
  reg  [1:0]  nxt_rst_wait;
  reg  [1:0]  nxt_clr_mask;
  reg  [1:0]  nxt_clr_wait;
  reg  [15:0] nxt_presc;
  reg  [31:0] nxt_count;
  reg         nxt_irq;

  // Reset value of the mode register, fields taken from it
  localparam [31:0] MODE_RST_VAL = `EST_MODE_RST;

  // Register select: finished access to one register offset
  function addr_hit;
    input       done;
    input [7:0] addr;
    input [7:0] off;
    begin
      addr_hit = done & (addr == off);
    end
  endfunction

  // Prescaler period end: divisor zero wraps through 65536 ticks
  function period_end;
    input [15:0] presc;
    input [15:0] div;
    begin
      period_end = (presc == div - 16'h0001);
    end
  endfunction

  // Wait counter step: load on a request, count slow edges down otherwise
  function [1:0] wait_step;
    input       req;
    input       tick;
    input [1:0] cnt;
    begin
      if (req) begin
        wait_step = `EST_SYNC_SLOW;
      end else if (tick && cnt != 2'h0) begin
        wait_step = cnt - 2'h1;
      end else begin
        wait_step = cnt;
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Slow clock synchroniser and rising edge detect

  // Shift the pin into the synchroniser chain
  always @* begin
    nxt_slow_sync = {slow_sync_ff[1:0], slow_clk};
  end

  // Synchroniser and edge stage registers
  always @(posedge sys_clk) begin
    if (rst) begin
      slow_sync_ff <= 3'h0;
    end else begin
      slow_sync_ff <= nxt_slow_sync;
    end
  end

  // Edge taken from second and third stages only
  assign slow_tick = slow_sync_ff[1] & ~slow_sync_ff[2];

  ////////////////////////////////////////////////////////////////////////////
  // APB decode: access phase lasts two cycles, pready registered

  assign acc_done   = psel & penable & pready;
  assign wr_done    = acc_done & pwrite & ~pslverr;
  assign rd_done    = acc_done & ~pwrite & ~pslverr;
  assign mode_wr    = addr_hit(wr_done, paddr, `EST_OFF_MODE);
  assign alarm_wr   = addr_hit(wr_done, paddr, `EST_OFF_ALARM);
  assign restart_wr = mode_wr & pwdata[`EST_RESTART_BIT];
  assign status_rd  = addr_hit(rd_done, paddr, `EST_OFF_STATUS);
  assign evt_clr_wr = addr_hit(wr_done, paddr, `EST_OFF_EVT_CLR);

  // Read data and error answer
  always @* begin
    nxt_rdata = 32'h0000_0000;
    nxt_err   = 1'b0;
    case (paddr)
      `EST_OFF_MODE:    nxt_rdata = {14'h0000, mode_ien_ff, mode_div_ff};
      `EST_OFF_ALARM:   nxt_rdata = alarm_ff;
      `EST_OFF_COUNT:   nxt_rdata = count_ff;
      `EST_OFF_STATUS:  nxt_rdata = {30'h0000_0000, flags_ff};
      `EST_OFF_EVT_CLR: nxt_rdata = 32'h0000_0000;
      default:          nxt_err   = 1'b1;
    endcase
  end

  // Bus answer next values: one wait state, answer for one cycle
  always @* begin
    nxt_ready  = psel & penable & ~pready;
    nxt_slverr = nxt_ready & nxt_err;
    nxt_prdata = 32'h0000_0000;
    if (nxt_ready && !pwrite) begin
      nxt_prdata = nxt_rdata;
    end
  end

  // Bus answer registers
  always @(posedge sys_clk) begin
    if (rst) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= nxt_ready;
      pslverr <= nxt_slverr;
      prdata  <= nxt_prdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode and alarm registers

  // Mode and alarm next values; the restart bit is never stored
  always @* begin
    nxt_mode_div = mode_div_ff;
    nxt_mode_ien = mode_ien_ff;
    nxt_alarm    = alarm_ff;
    if (mode_wr) begin
      nxt_mode_div = pwdata[`EST_DIV_MSB:0];
      nxt_mode_ien = pwdata[`EST_TICK_IEN_BIT:`EST_ALM_IEN_BIT];
    end
    if (alarm_wr) begin
      nxt_alarm = pwdata;
    end
  end

  // Mode and alarm registers
  always @(posedge sys_clk) begin
    if (rst) begin
      mode_div_ff <= MODE_RST_VAL[`EST_DIV_MSB:0];
      mode_ien_ff <= MODE_RST_VAL[`EST_TICK_IEN_BIT:`EST_ALM_IEN_BIT];
      alarm_ff    <= `EST_ALARM_RST;
    end else begin
      mode_div_ff <= nxt_mode_div;
      mode_ien_ff <= nxt_mode_ien;
      alarm_ff    <= nxt_alarm;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Delayed restart and flag clear, counted in slow clock edges

  assign rst_fire = rst_pend_ff & slow_tick & (rst_wait_ff == 2'h1);
  assign clr_fire = (clr_mask_ff != 2'h0) & slow_tick & (clr_wait_ff == 2'h1);

  always @(posedge sys_clk) begin
    if (rst) begin
      rst_pend_ff <= 1'b0;
      rst_wait_ff <= 2'h0;
      clr_mask_ff <= 2'h0;
      clr_wait_ff <= 2'h0;
    end else begin
      rst_wait_ff <= nxt_rst_wait;
      rst_pend_ff <= nxt_rst_pend;
      clr_wait_ff <= nxt_clr_wait;
      clr_mask_ff <= nxt_clr_mask;
    end
  end

  // Wait and mask next values; clear masks accumulate while waiting
  always @* begin
    nxt_rst_wait = wait_step(restart_wr, slow_tick, rst_wait_ff);
    nxt_rst_pend = restart_wr | (rst_pend_ff & ~rst_fire);
    nxt_clr_wait = wait_step(status_rd | evt_clr_wr, slow_tick, clr_wait_ff);
    nxt_clr_mask = clr_mask_ff;
    if (status_rd) begin
      nxt_clr_mask = 2'h3;
    end else if (evt_clr_wr) begin
      nxt_clr_mask = clr_mask_ff | pwdata[1:0];
    end else if (clr_fire) begin
      nxt_clr_mask = 2'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Prescaler and count

  // Period end when prescaler reaches divisor minus one; zero wraps to 65536
  assign inc_now = slow_tick & ~rst_fire & period_end(presc_ff, mode_div_ff);
  assign alm_now = (count_ff == alarm_ff);

  // Prescaler and count next values; restart wins over increment
  always @* begin
    nxt_presc = presc_ff;
    nxt_count = count_ff;
    if (rst_fire) begin
      nxt_presc = 16'h0000;
      nxt_count = `EST_COUNT_RST;
    end else if (inc_now) begin
      nxt_presc = 16'h0000;
      nxt_count = count_ff + 32'h0000_0001;
    end else if (slow_tick) begin
      nxt_presc = presc_ff + 16'h0001;
    end
  end

  // Prescaler and count registers
  always @(posedge sys_clk) begin
    if (rst) begin
      presc_ff <= 16'h0000;
      count_ff <= `EST_COUNT_RST;
    end else begin
      presc_ff <= nxt_presc;
      count_ff <= nxt_count;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky flags: a set in the clearing cycle wins

  always @* begin
    nxt_flags = flags_ff;
    if (clr_fire) begin
      nxt_flags = flags_ff & ~clr_mask_ff;
    end
    if (inc_now) begin
      nxt_flags[`EST_TICK_FLAG_BIT] = 1'b1;
    end
    if (alm_now) begin
      nxt_flags[`EST_ALM_FLAG_BIT] = 1'b1;
    end
    nxt_irq = |(nxt_flags & mode_ien_ff);
  end

  // Sticky flag registers
  always @(posedge sys_clk) begin
    if (rst) begin
      flags_ff <= 2'h0;
    end else begin
      flags_ff <= nxt_flags;
    end
  end

  // Interrupt output, in step with the flags
  always @(posedge sys_clk) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= nxt_irq;
    end
  end

endmodule // est_timer

// File: test/est_timer_properties.sv
/* Port checker of est_timer.
   Assumes the bind below and an APB master on sys_clk. */
`timescale 1ns/100ps
module est_props (
  // Clock and reset
  input wire        sys_clk,
  input wire        rst,
  // APB
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [7:0]  paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  // Interrupt
  input wire        irq
);
  reg  [17:0] md_ff;
  reg  [31:0] al_ff;
  wire        wr = psel & penable & pready & pwrite;
  wire        rd = pready & ~pwrite;
  ////////////////////////////////
  // Shadow of the writable fields
  always @(posedge sys_clk) begin
    if (rst) begin
      md_ff <= 18'h08000;
      al_ff <= 32'hffffffff;
    end else if (wr && paddr == 8'h00) begin
      md_ff <= pwdata[17:0];
    end else if (wr && paddr == 8'h04) begin
      al_ff <= pwdata;
    end
  end
  ////////////////////////////////
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_wait_state: assert property ($rose(penable) |=> pready) // One wait state
    else $error("pready late");
  a_ready_pulse: assert property (pready |=> !pready) // Single cycle answer
    else $error("pready held");
  a_unmapped_err: assert property (pready && paddr > 8'h10 |-> pslverr && prdata == 0) // Hole
    else $error("no slave error");
  a_status_rsvd: assert property (rd && paddr == 8'h0c |-> prdata[31:2] == 0)
    else $error("status spare bits");
  a_mode_rb: assert property (rd && paddr == 8'h00 |-> prdata[18:0] == {1'b0, md_ff})
    else $error("mode readback");
  a_alarm_rb: assert property (rd && paddr == 8'h04 |-> prdata == al_ff)
    else $error("alarm readback");
  a_irq_masked: assert property (md_ff[17:16] == 0 && $past(md_ff[17:16]) == 0 |-> !irq)
    else $error("irq while masked");
  a_irq_rise: assert property ($rose(irq) |-> (md_ff[17:16] | $past(md_ff[17:16])) != 0)
    else $error("irq rose masked");
endmodule // est_props

bind est_timer est_props est_props_inst (.sys_clk(sys_clk), .rst(rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .irq(irq));

// File: test/tb_top.sv
/* Self-checking bench of est_timer.
   Assumes the slow clock at 10 sys_clk periods. */
`timescale 1ns/100ps
`include "est_defines.vh"
module tb_top;
  reg         sys_clk, rst, slow_clk, psel, penable, pwrite, er;
  reg  [7:0]  paddr;
  reg  [31:0] pwdata, rd_v;
  wire [31:0] prdata;
  wire        pready, pslverr, irq;
  integer     err_count, n_checks;
  est_timer est_timer_inst (.sys_clk(sys_clk), .rst(rst), .slow_clk(slow_clk), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq));
  ////////////////////////////////
  // Compare and count
  task chk(input [31:0] seen, input [31:0] exp, input [63:0] what);
    n_checks = n_checks + 1;
    if (seen !== exp) begin
      err_count = err_count + 1;
      $display("[FAIL] %0s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Verdict and end of run
  task test_done;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // One APB transfer
  task apb(input w, input [7:0] a, input [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1) @(posedge sys_clk);
    rd_v = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Fixed phase after a slow edge
  task align;
    @(posedge slow_clk);
    repeat (5) @(posedge sys_clk);
  endtask
  // Restart, let e slow edges pass, read count
  task measure(input [15:0] dv, input integer e, input [1:0] en);
    integer i;
    align;
    apb(1'b1, `EST_OFF_MODE, {13'h0, 1'b1, en, dv});
    for (i = 0; i < e; i = i + 1) align;
    apb(1'b0, `EST_OFF_COUNT, 32'h0);
    chk(rd_v, (e - 2) / (dv == 0 ? 65536 : dv), "count");
  endtask
  ////////////////////////////////
  // Reset values and hole
  task test_reset;
    apb(1'b0, `EST_OFF_MODE, 32'h0);
    chk(rd_v, `EST_MODE_RST, "mode");
    apb(1'b0, `EST_OFF_ALARM, 32'h0);
    chk(rd_v, `EST_ALARM_RST, "alarm");
    apb(1'b0, `EST_OFF_STATUS, 32'h0);
    chk(rd_v, 32'h0, "status");
    apb(1'b0, 8'h20, 32'h0);
    chk(er, 1'b1, "slverr");
  endtask
  // Alarm, masking, read clear delay
  task test_flags;
    apb(1'b1, `EST_OFF_ALARM, 32'h5);
    measure(16'h1, 12, 2'b01);
    chk(irq, 1'b1, "irq");
    apb(1'b1, `EST_OFF_ALARM, 32'hffffffff);
    measure(16'h0, 4, 2'b01);
    apb(1'b1, `EST_OFF_MODE, 32'h0);
    repeat (3) @(posedge sys_clk);
    chk(irq, 1'b0, "irq");
    apb(1'b1, `EST_OFF_MODE, 32'h20000);
    repeat (3) @(posedge sys_clk);
    chk(irq, 1'b1, "irq");
    apb(1'b1, `EST_OFF_COUNT, 32'h55);
    apb(1'b0, `EST_OFF_COUNT, 32'h0);
    chk(rd_v, 32'h0, "count");
    apb(1'b0, `EST_OFF_COUNT, 32'h0);
    chk(rd_v, 32'h0, "count");
    apb(1'b0, `EST_OFF_STATUS, 32'h0);
    chk(rd_v, 32'h3, "status");
    chk(irq, 1'b1, "irq");
    apb(1'b0, `EST_OFF_STATUS, 32'h0);
    chk(rd_v, 32'h3, "status");
    repeat (3) @(posedge slow_clk);
    apb(1'b0, `EST_OFF_STATUS, 32'h0);
    chk(rd_v, 32'h0, "status");
    chk(irq, 1'b0, "irq");
  endtask
  // Event clear of the unset alarm flag through the event clear register leaves the tick flag set
  task test_evt_clr;
    measure(16'h1, 4, 2'b00);
    apb(1'b1, `EST_OFF_MODE, 32'h0);
    apb(1'b1, `EST_OFF_EVT_CLR, 32'h1);
    repeat (3) @(posedge slow_clk);
    apb(1'b0, `EST_OFF_STATUS, 32'h0);
    chk(rd_v, 32'h2, "status");
  endtask
  ////////////////////////////////
  // Clocks
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  initial begin
    slow_clk = 1'b0;
    #1;
    forever #20 slow_clk = ~slow_clk;
  end
  // Watchdog
  initial begin
    #80000;
    err_count = err_count + 1;
    test_done;
  end
  // Main sequence
  initial begin
    err_count = 0;
    n_checks = 0;
    rst = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = 43'h0;
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    test_reset;
    measure(16'h3, 14, 2'b00);
    measure(16'h1, 8, 2'b00);
    measure(16'h2, 9, 2'b00);
    measure(16'h0, 24, 2'b00);
    test_flags;
    test_evt_clr;
    test_done;
  end
endmodule // tb_top
